// file: design/gcd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "gcd_cfg.svh"

module gcd_top
    import gcd_pkg::*;
#(
    parameter int STANDSTILL_SHORT = `GCD_STANDSTILL_SHORT,
    parameter int STANDSTILL_LONG  = `GCD_STANDSTILL_LONG
) (
    input  wire logic                            clk,
    input  wire logic                            resetn,
    input  wire logic                            link_sck,
    input  wire logic                            chip_select_n,
    input  wire logic                            sdi,
    output logic                                 sdo_o,
    output logic                                 sdo_oe,
    input  wire logic                            drive_disable_n,
    input  wire logic                            dir_in,
    input  wire logic [3:0]                      off_time_setting,
    input  wire logic                            step_pulse,
    input  wire logic                            over_temp,
    input  wire logic                            short_to_ground,
    input  wire logic                            pump_undervolt,
    input  wire logic                            prewarn,
    input  wire logic                            stall,
    input  wire logic                            index_pos,
    input  wire logic                            chopper_on_second,
    input  wire logic                            skip_increment,
    input  wire logic                            pwm_velocity_ok,
    output logic [`GCD_GLOBAL_CONFIG_W-1:0]      global_config_q,
    output logic                                 recalibrate_req,
    output logic                                 standstill,
    output logic                                 pwm_mode_en,
    output logic                                 step_filter_en,
    output logic                                 motor_dir,
    output logic                                 diag_out_a_o,
    output logic                                 diag_out_a_oe,
    output logic                                 diag_out_b_o,
    output logic                                 diag_out_b_oe
);

    localparam int CFG_W = `GCD_GLOBAL_CONFIG_W;
    localparam int SS_W  = `GCD_STANDSTILL_W;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // open collector pulls low when active; push-pull drives high
    function automatic gcd_pin_t pin_drive(input logic active, input logic push_pull);
        gcd_pin_t p;
        p.o  = push_pull ? active : 1'b0;
        p.oe = push_pull ? 1'b1 : active;
        return p;
    endfunction

    function automatic logic [31:0] read_data(input logic [`GCD_ADDR_W-1:0] addr,
                                              input logic [CFG_W-1:0]       cfg);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (addr == `GCD_ADDR_GLOBAL_CONFIG) begin
            d = {{(32-CFG_W){1'b0}}, cfg};
        end
        return d;
    endfunction

    // ------------------------------------------------------------------
    // link domain and crossings
    // ------------------------------------------------------------------

    logic [`GCD_FRAME_BITS-1:0] rx_word;
    logic                       rx_full;
    logic [`GCD_FRAME_BITS-1:0] tx_word_reg;
    logic [`GCD_FRAME_BITS-1:0] tx_word_next;
    logic [3:0]                 pins_sync;

    gcd_spi_link u_link (
        .link_sck      (link_sck),
        .chip_select_n (chip_select_n),
        .sdi           (sdi),
        .tx_word       (tx_word_reg),
        .rx_word       (rx_word),
        .rx_full       (rx_full),
        .sdo_o         (sdo_o),
        .sdo_oe        (sdo_oe)
    );

    // chip select idles high; disable pin idles high (driver enabled)
    gcd_sync #(
        .WIDTH (4),
        .INIT  (64'h5)
    ) u_sync (
        .clk      (clk),
        .resetn   (resetn),
        .async_in ({rx_full, drive_disable_n, dir_in, chip_select_n}),
        .sync_out (pins_sync)
    );

    logic cs_n_s;
    logic dir_s;
    logic disable_n_s;
    logic full_s;

    assign cs_n_s      = pins_sync[0];
    assign dir_s       = pins_sync[1];
    assign disable_n_s = pins_sync[2];
    assign full_s      = pins_sync[3];

    // ------------------------------------------------------------------
    // frame acceptance and register access
    // ------------------------------------------------------------------

    gcd_state_t       state_reg;
    gcd_state_t       state_next;
    logic             full_seen_reg;
    logic             full_seen_next;
    logic [CFG_W-1:0] cfg_reg;
    logic [CFG_W-1:0] cfg_next;
    gcd_cmd_t         cmd;
    logic             standstill_reg;

    assign cmd = gcd_cmd_t'(rx_word);

    // rx_word is stable here: sck has stopped before chip select rose
    always_comb begin
        state_next     = state_reg;
        full_seen_next = full_seen_reg;
        cfg_next       = cfg_reg;
        tx_word_next   = tx_word_reg;
        case (state_reg)
            GCD_IDLE: begin
                if (!cs_n_s) begin
                    state_next     = GCD_FRAME;
                    full_seen_next = 1'b0;
                end
            end
            GCD_FRAME: begin
                // the full flag clears with chip select, so keep it sticky
                if (full_s) begin
                    full_seen_next = 1'b1;
                end
                if (cs_n_s) begin
                    state_next = GCD_TAKE;
                end
            end
            GCD_TAKE: begin
                state_next = GCD_IDLE;
                // short frames are dropped whole
                if (full_seen_reg) begin
                    if (cmd.write && cmd.addr == `GCD_ADDR_GLOBAL_CONFIG) begin
                        cfg_next = cmd.data[CFG_W-1:0];
                    end
                    tx_word_next = {8'h00, read_data(cmd.addr, cfg_next)};
                    tx_word_next[`GCD_STAT_STANDSTILL] = standstill_reg;
                    tx_word_next[`GCD_STAT_STALL]      = stall;
                end
            end
            default: begin
                state_next = GCD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg     <= GCD_IDLE;
            full_seen_reg <= 1'b0;
            cfg_reg       <= `GCD_GLOBAL_CONFIG_RST;
            tx_word_reg   <= '0;
        end else begin
            state_reg     <= state_next;
            full_seen_reg <= full_seen_next;
            cfg_reg       <= cfg_next;
            tx_word_reg   <= tx_word_next;
        end
    end

    // ------------------------------------------------------------------
    // standstill timer
    // ------------------------------------------------------------------

    logic [SS_W-1:0] ss_cnt_reg;
    logic [SS_W-1:0] ss_cnt_next;
    logic [SS_W-1:0] ss_limit;
    logic            standstill_next;

    always_comb begin
        ss_limit = cfg_reg[`GCD_FAST_STANDSTILL] ? SS_W'(STANDSTILL_SHORT)
                                                  : SS_W'(STANDSTILL_LONG);
        if (step_pulse) begin
            ss_cnt_next = '0;
        end else if (ss_cnt_reg < ss_limit) begin
            ss_cnt_next = ss_cnt_reg + SS_W'(1);
        end else begin
            ss_cnt_next = ss_cnt_reg;
        end
        standstill_next = !step_pulse && (ss_cnt_next >= ss_limit);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ss_cnt_reg     <= '0;
            standstill_reg <= 1'b0;
        end else begin
            ss_cnt_reg     <= ss_cnt_next;
            standstill_reg <= standstill_next;
        end
    end

    // ------------------------------------------------------------------
    // driver settings
    // ------------------------------------------------------------------

    logic recal_reg;
    logic recal_next;
    logic pwm_reg;
    logic pwm_next;
    logic filt_reg;
    logic filt_next;
    logic dir_reg;
    logic dir_next;

    // the host is trusted to switch pwm on only at standstill
    always_comb begin
        recal_next = cfg_reg[`GCD_RECALIBRATE] &&
                     (!disable_n_s || off_time_setting == 4'h0);
        pwm_next   = cfg_reg[`GCD_PWM_MODE_EN] && pwm_velocity_ok;
        filt_next  = cfg_reg[`GCD_STEP_FILTER];
        dir_next   = dir_s ^ cfg_reg[`GCD_DIR_INVERT];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            recal_reg <= 1'b0;
            pwm_reg   <= 1'b0;
            filt_reg  <= 1'b1;
            dir_reg   <= 1'b0;
        end else begin
            recal_reg <= recal_next;
            pwm_reg   <= pwm_next;
            filt_reg  <= filt_next;
            dir_reg   <= dir_next;
        end
    end

    // ------------------------------------------------------------------
    // diagnostic outputs
    // ------------------------------------------------------------------

    logic     skip_tgl_reg;
    logic     skip_tgl_next;
    logic     act_a;
    logic     act_b;
    gcd_pin_t out_a_reg;
    gcd_pin_t out_a_next;
    gcd_pin_t out_b_reg;
    gcd_pin_t out_b_next;

    always_comb begin
        skip_tgl_next = skip_tgl_reg;
        if (skip_increment && cfg_reg[`GCD_SKIP_TOGGLE_OUT_B]) begin
            skip_tgl_next = ~skip_tgl_reg;
        end
        act_a = (cfg_reg[`GCD_FAULT_TO_OUT_A] &&
                 (over_temp || short_to_ground || pump_undervolt)) ||
                (cfg_reg[`GCD_PREWARN_TO_OUT_A] && prewarn) ||
                (cfg_reg[`GCD_STALL_TO_OUT_A] && stall);
        // mixing the toggle with other sources gives a meaningless level
        act_b = (cfg_reg[`GCD_STALL_TO_OUT_B] && stall) ||
                (cfg_reg[`GCD_INDEX_TO_OUT_B] && index_pos) ||
                (cfg_reg[`GCD_CHOPPER_ON_TO_OUT_B] && chopper_on_second) ||
                (cfg_reg[`GCD_SKIP_TOGGLE_OUT_B] && skip_tgl_reg);
        out_a_next = pin_drive(act_a, cfg_reg[`GCD_OUT_A_DRIVE_TYPE]);
        out_b_next = pin_drive(act_b, cfg_reg[`GCD_OUT_B_DRIVE_TYPE]);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            skip_tgl_reg <= 1'b0;
            out_a_reg    <= '{o: 1'b0, oe: 1'b1};
            out_b_reg    <= '{o: 1'b0, oe: 1'b0};
        end else begin
            skip_tgl_reg <= skip_tgl_next;
            out_a_reg    <= out_a_next;
            out_b_reg    <= out_b_next;
        end
    end

    assign global_config_q = cfg_reg;
    assign recalibrate_req = recal_reg;
    assign standstill      = standstill_reg;
    assign pwm_mode_en     = pwm_reg;
    assign step_filter_en  = filt_reg;
    assign motor_dir       = dir_reg;
    assign diag_out_a_o    = out_a_reg.o;
    assign diag_out_a_oe   = out_a_reg.oe;
    assign diag_out_b_o    = out_b_reg.o;
    assign diag_out_b_oe   = out_b_reg.oe;

endmodule

`default_nettype wire

// file: design/gcd_cfg.svh
`ifndef GCD_CFG_SVH
`define GCD_CFG_SVH

// serial frame layout
`define GCD_FRAME_BITS          40
`define GCD_CNT_W               6
`define GCD_WRITE_POS           39
`define GCD_ADDR_HI             38
`define GCD_ADDR_LO             32
`define GCD_ADDR_W              7

// register map
`define GCD_ADDR_GLOBAL_CONFIG  7'h00
`define GCD_GLOBAL_CONFIG_W     17
`define GCD_GLOBAL_CONFIG_RST   17'h00008

// global_config field positions
`define GCD_RECALIBRATE         0
`define GCD_FAST_STANDSTILL     1
`define GCD_PWM_MODE_EN         2
`define GCD_STEP_FILTER         3
`define GCD_DIR_INVERT          4
`define GCD_FAULT_TO_OUT_A      5
`define GCD_PREWARN_TO_OUT_A    6
`define GCD_STALL_TO_OUT_A      7
`define GCD_STALL_TO_OUT_B      8
`define GCD_INDEX_TO_OUT_B      9
`define GCD_CHOPPER_ON_TO_OUT_B 10
`define GCD_SKIP_TOGGLE_OUT_B   11
`define GCD_OUT_A_DRIVE_TYPE    12
`define GCD_OUT_B_DRIVE_TYPE    13

// status byte positions within the returned frame
`define GCD_STAT_STANDSTILL     35
`define GCD_STAT_STALL          34

// standstill timeouts in system clocks
`define GCD_STANDSTILL_SHORT    262144
`define GCD_STANDSTILL_LONG     1048576
`define GCD_STANDSTILL_W        21

`endif

// file: design/gcd_pkg.sv
package gcd_pkg;

    typedef struct packed {
        logic        write;
        logic [6:0]  addr;
        logic [31:0] data;
    } gcd_cmd_t;

    typedef struct packed {
        logic o;
        logic oe;
    } gcd_pin_t;

    typedef enum logic [1:0] {
        GCD_IDLE,
        GCD_FRAME,
        GCD_TAKE
    } gcd_state_t;

endpackage

// file: design/gcd_sync.sv
`timescale 1ns/1ps
`default_nettype none

module gcd_sync #(
    parameter int          WIDTH = 1,
    parameter logic [63:0] INIT  = 64'h0
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= INIT[WIDTH-1:0];
            sync_reg <= INIT[WIDTH-1:0];
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule

`default_nettype wire

// file: design/gcd_spi_link.sv
`timescale 1ns/1ps
`default_nettype none
`include "gcd_cfg.svh"

module gcd_spi_link
    import gcd_pkg::*;
(
    input  wire logic                        link_sck,
    input  wire logic                        chip_select_n,
    input  wire logic                        sdi,
    input  wire logic [`GCD_FRAME_BITS-1:0]  tx_word,
    output logic      [`GCD_FRAME_BITS-1:0]  rx_word,
    output logic                             rx_full,
    output logic                             sdo_o,
    output logic                             sdo_oe
);

    localparam logic [`GCD_CNT_W-1:0] FRAME_CNT = `GCD_CNT_W'(`GCD_FRAME_BITS);
    localparam logic [`GCD_CNT_W-1:0] LAST_POS  = `GCD_CNT_W'(`GCD_FRAME_BITS - 1);

    logic [`GCD_FRAME_BITS-1:0] shift_reg;
    logic [`GCD_FRAME_BITS-1:0] shift_next;
    logic [`GCD_CNT_W-1:0]      cnt_reg;
    logic [`GCD_CNT_W-1:0]      cnt_next;
    logic                       full_reg;
    logic                       full_next;
    logic                       sdo_reg;
    logic                       sdo_next;

    // only the last 40 bits before chip select rises remain
    always_comb begin
        shift_next = {shift_reg[`GCD_FRAME_BITS-2:0], sdi};
        cnt_next   = (cnt_reg == FRAME_CNT) ? cnt_reg : cnt_reg + `GCD_CNT_W'(1);
        full_next  = full_reg | (cnt_next == FRAME_CNT);
    end

    // data keeps its value after the frame; sck stands still then
    always_ff @(posedge link_sck) begin
        shift_reg <= shift_next;
    end

    always_ff @(posedge link_sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            cnt_reg  <= '0;
            full_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            full_reg <= full_next;
        end
    end

    // read data first, then bits received 40 clocks earlier
    always_comb begin
        if (cnt_reg < FRAME_CNT) begin
            sdo_next = tx_word[LAST_POS - cnt_reg];
        end else begin
            sdo_next = shift_reg[`GCD_FRAME_BITS-1];
        end
    end

    always_ff @(negedge link_sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            sdo_reg <= 1'b0;
        end else begin
            sdo_reg <= sdo_next;
        end
    end

    // first bit must stand before any sck edge of the frame
    assign sdo_o   = (cnt_reg == '0) ? tx_word[`GCD_FRAME_BITS-1] : sdo_reg;
    assign sdo_oe  = ~chip_select_n;
    assign rx_word = shift_reg;
    assign rx_full = full_reg;

endmodule

`default_nettype wire

// file: verification/gcd_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "gcd_cfg.svh"

module gcd_top_monitor (
    input wire logic                           clk,
    input wire logic                           resetn,
    input wire logic                           chip_select_n,
    input wire logic [3:0]                     off_time_setting,
    input wire logic                           step_pulse,
    input wire logic                           over_temp,
    input wire logic                           index_pos,
    input wire logic                           pwm_velocity_ok,
    input wire logic [`GCD_GLOBAL_CONFIG_W-1:0] global_config_q,
    input wire logic                           recalibrate_req,
    input wire logic                           standstill,
    input wire logic                           pwm_mode_en,
    input wire logic                           step_filter_en,
    input wire logic                           diag_out_a_o,
    input wire logic                           diag_out_a_oe,
    input wire logic                           diag_out_b_o,
    input wire logic                           diag_out_b_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // updates land only after the frame has closed
    cfg_update_a: assert property ($changed(global_config_q) |-> chip_select_n)
        else $error("config changed while frame open");
    filter_follow_a: assert property (step_filter_en == $past(global_config_q[3]))
        else $error("step filter enable wrong");
    pwm_follow_a: assert property (pwm_mode_en == $past(global_config_q[2] && pwm_velocity_ok))
        else $error("pwm mode enable wrong");
    recal_req_a: assert property (global_config_q[0] && off_time_setting == 4'h0 |=> recalibrate_req)
        else $error("recalibration not requested");
    still_clear_a: assert property (step_pulse |=> !standstill)
        else $error("standstill kept after step");
    out_a_oc_a: assert property (!global_config_q[12] && $stable(global_config_q[12]) |-> !diag_out_a_o)
        else $error("open collector pin a driven high");
    fault_route_a: assert property (global_config_q[5] && over_temp
        |=> diag_out_a_oe && diag_out_a_o == $past(global_config_q[12]))
        else $error("fault not shown on pin a");
    index_route_a: assert property (global_config_q[9] && index_pos
        |=> diag_out_b_oe && diag_out_b_o == $past(global_config_q[13]))
        else $error("index not shown on pin b");
    // no disable here: the pin must show reset itself
    reset_pin_a: assert property (disable iff (1'b0) !resetn |-> !diag_out_a_o && diag_out_a_oe)
        else $error("pin a not low in reset");

    cover property ($changed(global_config_q));
    cover property ($rose(standstill));
    cover property (global_config_q[9] && index_pos);
endmodule

bind gcd_top gcd_top_monitor u_mon (
    .clk              (clk),
    .resetn           (resetn),
    .chip_select_n    (chip_select_n),
    .off_time_setting (off_time_setting),
    .step_pulse       (step_pulse),
    .over_temp        (over_temp),
    .index_pos        (index_pos),
    .pwm_velocity_ok  (pwm_velocity_ok),
    .global_config_q  (global_config_q),
    .recalibrate_req  (recalibrate_req),
    .standstill       (standstill),
    .pwm_mode_en      (pwm_mode_en),
    .step_filter_en   (step_filter_en),
    .diag_out_a_o     (diag_out_a_o),
    .diag_out_a_oe    (diag_out_a_oe),
    .diag_out_b_o     (diag_out_b_o),
    .diag_out_b_oe    (diag_out_b_oe)
);

`default_nettype wire

// file: verification/gcd_host.sv
`timescale 1ns/1ps
`default_nettype none

module gcd_host (
    output logic      link_sck,
    output logic      chip_select_n,
    output logic      sdi,
    input  wire logic sdo_o
);
    localparam real HP = 62.5;

    initial begin
        link_sck = 1'b1;
        chip_select_n = 1'b1;
        sdi = 1'b1;
    end

    // n below 40 gives a cut-short frame on purpose
    task automatic xfer(input logic [39:0] w, input int n, output logic [39:0] r);
        r = '0;
        #7.3 chip_select_n = 1'b0;
        #HP;
        for (int j = 0; j < n; j++) begin
            link_sck = 1'b0;
            sdi = w[39-j];
            #HP;
            link_sck = 1'b1;
            r[39-j] = sdo_o;
            #HP;
        end
        // a stale level would hide a late sample
        sdi = ~sdi;
        chip_select_n = 1'b1;
        #400;
    endtask
endmodule

`default_nettype wire

// file: verification/global_config_diag_outputs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module global_config_diag_outputs_tb_top;
    logic        clk, resetn, dis_n, dir, step, ot, gnd_short, uv, pw, st, idx, chop, skp, vok;
    logic [3:0]  off_time;
    wire         sck, cs_n, sdi, sdo_o, sdo_oe, recal, still, pwm, filt, mdir, ao, aoe, bo, boe;
    wire  [16:0] q;
    logic [16:0] cfg, v;
    logic [31:0] nxt, r;
    logic [39:0] rsp;
    logic [32:0] q_exp[$];
    logic        chk_on;
    int          err_total, total_checks, cyc;
    event        rsp_ev;

    gcd_top #(.STANDSTILL_SHORT(16), .STANDSTILL_LONG(64)) DUT (
        .clk(clk), .resetn(resetn), .link_sck(sck), .chip_select_n(cs_n), .sdi(sdi),
        .sdo_o(sdo_o), .sdo_oe(sdo_oe), .drive_disable_n(dis_n), .dir_in(dir),
        .off_time_setting(off_time), .step_pulse(step), .over_temp(ot), .short_to_ground(gnd_short),
        .pump_undervolt(uv), .prewarn(pw), .stall(st), .index_pos(idx),
        .chopper_on_second(chop), .skip_increment(skp), .pwm_velocity_ok(vok),
        .global_config_q(q), .recalibrate_req(recal), .standstill(still), .pwm_mode_en(pwm),
        .step_filter_en(filt), .motor_dir(mdir), .diag_out_a_o(ao), .diag_out_a_oe(aoe),
        .diag_out_b_o(bo), .diag_out_b_oe(boe));
    gcd_host host (.link_sck(sck), .chip_select_n(cs_n), .sdi(sdi), .sdo_o(sdo_o));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [1:0] pin(input logic act, input logic pp);
        return pp ? {act, 1'b1} : {1'b0, act};
    endfunction

    task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
        total_checks++;
        if (e !== g) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // reply carries the read data of the frame before
    task automatic frame(input logic [7:0] a, input logic [31:0] d, input int n);
        q_exp.push_back({chk_on, nxt});
        host.xfer({a, d}, n, rsp);
        -> rsp_ev;
        if (n == 40) begin
            if (a == 8'h80)
                cfg = d[16:0];
            nxt = (a[6:0] == 7'h00) ? {15'h0, cfg} : 32'h0;
        end
        chk_on = 1'b1;
        tick(1);
        chk("cfg", cfg, q);
    endtask

    initial begin
        logic [32:0] e;
        forever begin
            @(rsp_ev);
            e = q_exp.pop_front();
            if (e[32])
                chk("reply", e[31:0], rsp[31:0]);
        end
    end

    // the serial output driver must be on exactly while selected
    always @(negedge sck) chk("sdo_oe", !cs_n, sdo_oe);

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_sim;
        end
    end

    initial begin
        {dir, step, ot, gnd_short, uv, pw, st, idx, chop, skp, vok} = '0;
        {chk_on, nxt} = '0;
        // a clean falling edge once every process waits on it
        resetn = 1'b1;
        dis_n = 1'b1;
        off_time = 4'h5;
        cfg = 17'h00008;
        r = $urandom(32'h1493);
        #1 resetn = 1'b0;
        tick(10);
        chk("rst_a", 2'b01, {ao, aoe});
        chk("rst_b", 1'b0, boe);
        chk("rst_cfg", {cfg, 1'b1}, {q, filt});
        resetn = 1'b1;
        tick(4);
        $display("test reset done");
        frame(8'h00, 32'h0, 40);
        frame(8'h00, 32'h0001FFFF, 40);
        frame(8'h85, 32'h0001FFFF, 40);
        frame(8'h80, 32'h0001C00C, 20);
        $display("test access done");
        repeat (6) begin
            v = 17'($urandom);
            v[11] = 1'b0;
            // no steps issued yet, so the motor stands still
            frame(8'h80, {15'h0, v}, 40);
            r = $urandom;
            {ot, gnd_short, uv, pw, st, idx, chop, vok, dis_n, dir} = r[9:0];
            off_time = r[10] ? 4'h0 : 4'h5;
            tick(5);
            chk("out_a", pin(v[5] & (ot | gnd_short | uv) | v[6] & pw | v[7] & st, v[12]), {ao, aoe});
            chk("out_b", pin(v[8] & st | v[9] & idx | v[10] & chop, v[13]), {bo, boe});
            chk("ctl", {v[0] & (!dis_n | off_time == 4'h0), v[2] & vok, v[3], dir ^ v[4]},
                {recal, pwm, filt, mdir});
        end
        $display("test diag done");
        frame(8'h80, 32'h00002800, 40);
        for (int k = 0; k < 3; k++) begin
            tick(3);
            chk("skip", {k[0], 1'b1}, {bo, boe});
            skp = 1'b1;
            tick(1);
            skp = 1'b0;
        end
        $display("test skip done");
        for (int k = 0; k < 2; k++) begin
            frame(8'h80, k ? 32'h0 : 32'h2, 40);
            step = 1'b1;
            tick(1);
            step = 1'b0;
            tick(k ? 50 : 10);
            chk("still", 1'b0, still);
            tick(k ? 20 : 10);
            chk("still", 1'b1, still);
        end
        $display("test standstill done");
        end_sim;
    end
endmodule

`default_nettype wire
